// ---- core/converter_control.sv ----
// converter control register with its serial access port and mode decoder
// assumes serial pins are synchronous to mclk and sclk is much slower than mclk
//
// Overview of operation
// - grouping 00xx gives four independent channels
// - codes 0100-0111 give interleaved pairs AC,BC,AD,BD
// - codes 1000-1011 give one channel, output A-D
// - codes 1100-1111 give common input, input A-D
// - powerdown 00 all active (dual: both pair members only), 11 all standby
// - dual mode code 01 idles A/B member
// - code 10 idles C,D or C/D member
// - single or common mode: 01,10 mean full standby
// - coding bit 7, powerdown 5:4, grouping 3:0
// - bit 8 selects nominal or full bandwidth
// - bit 12 routes test pattern to outputs
// - frame: 8-bit address with write flag, 16 data
// - reset pin and soft reset restore defaults
`timescale 1ns/1ps
`include "mode_ctrl_params.svh"

module converter_control
	import mode_ctrl_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic serial_reset_n,
	input wire logic sclk,
	input wire logic csn,
	input wire logic mosi,
	output logic miso,
	input wire logic realign_pulse_p,
	input wire logic realign_pulse_n,
	output mode_status_t mode_status,
	output logic realign_pending
);

	spi_state_t state_q;
	logic sclk_prev_q;
	logic [4:0] bit_cnt_q;
	logic [`FRAME_BITS-2:0] shift_q;
	logic [`ADDR_BITS-1:0] addr_q;
	logic [`DATA_BITS-1:0] out_q;
	logic miso_q;
	logic [`DATA_BITS-1:0] ctrl_q;
	logic [`DATA_BITS-1:0] ctrl_d;
	mode_status_t status_q;
	logic pending_q;
	logic sclk_rise;
	logic sclk_fall;
	logic [`ADDR_BITS-1:0] addr_word;
	logic [`DATA_BITS-1:0] data_word;
	logic frame_end;
	logic wr_ctrl;
	logic soft_rst;
	logic layout_change;
	logic realign_seen;

	// turn the five register fields into the analog setup
	function automatic mode_status_t decode(input logic [`DATA_BITS-1:0] c);
		mode_status_t s;
		logic [1:0] pd;
		logic [3:0] pair;
		logic [3:0] ab_member;
		s = '0;
		pd = c[`PD_LSB +: 2];
		pair = 4'h0;
		ab_member = 4'h0;
		s.route_sel = c[`GROUP_LSB +: 2];
		s.gray_sel = c[`GRAY_BIT];
		s.input_bw_sel = c[`BW_BIT];
		s.test_pattern_en = c[`TEST_BIT];
		case (c[`GROUP_LSB+2 +: 2])
			2'b00:
			begin
				s.grouping = GROUP_QUAD;
				s.route_sel = 2'b00; // low bits ignored here
				case (pd)
					2'b00: s.core_active = 4'hf;
					2'b01: s.core_active = 4'hc;
					2'b10: s.core_active = 4'h3;
					default: s.core_active = 4'h0;
				endcase
			end
			2'b01:
			begin
				s.grouping = GROUP_DUAL;
				ab_member = c[`GROUP_LSB] ? 4'h2 : 4'h1;
				pair = ab_member | (c[`GROUP_LSB+1] ? 4'h8 : 4'h4);
				case (pd)
					2'b00: s.core_active = pair;
					2'b01: s.core_active = pair & ~ab_member;
					2'b10: s.core_active = ab_member;
					default: s.core_active = 4'h0;
				endcase
			end
			2'b10:
			begin
				s.grouping = GROUP_SINGLE;
				s.core_active = (pd == 2'b00) ? 4'hf : 4'h0;
			end
			default:
			begin
				s.grouping = GROUP_COMMON;
				s.core_active = (pd == 2'b00) ? 4'hf : 4'h0;
			end
		endcase
		return s;
	endfunction

	// serial clock edges seen on mclk; sclk idles low, so reset makes no false edge
	assign sclk_rise = sclk & ~sclk_prev_q;
	assign sclk_fall = ~sclk & sclk_prev_q;

	// address and data words as they stand with the bit now arriving
	assign addr_word = {shift_q[`ADDR_BITS-2:0], mosi};
	assign data_word = {shift_q[`DATA_BITS-2:0], mosi};

	// a frame counts only on its last rise; frames cut by csn never get here
	assign frame_end = (state_q == SPI_DATA) && !csn && sclk_rise
		&& (bit_cnt_q == 5'(`FRAME_BITS - 1));
	assign wr_ctrl = frame_end && addr_q[`ADDR_BITS-1]
		&& (addr_q[`ADDR_BITS-2:0] == `CTRL_ADDR);
	assign soft_rst = frame_end && addr_q[`ADDR_BITS-1]
		&& (addr_q[`ADDR_BITS-2:0] == `SOFT_RESET_ADDR)
		&& data_word[`SOFT_RESET_BIT];

	// realign taken only on a true differential pulse
	assign realign_seen = realign_pulse_p & ~realign_pulse_n;

	// previous serial clock level
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sclk_prev_q <= 1'b0;
		else
			sclk_prev_q <= sclk;
	end

	// frame sequencer: address phase then data phase, chip select aborts
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= SPI_IDLE;
			bit_cnt_q <= 5'h00;
			shift_q <= '0;
			addr_q <= 8'h00;
		end
		else if (csn || !serial_reset_n)
		begin
			state_q <= csn ? SPI_IDLE : SPI_ADDR;
			bit_cnt_q <= 5'h00;
		end
		else
		begin
			if (state_q == SPI_IDLE)
				state_q <= SPI_ADDR;
			if (sclk_rise && (state_q == SPI_ADDR || state_q == SPI_DATA))
			begin
				shift_q <= {shift_q[`FRAME_BITS-3:0], mosi};
				bit_cnt_q <= bit_cnt_q + 5'h01;
				if (state_q == SPI_ADDR && bit_cnt_q == 5'(`ADDR_BITS - 1))
				begin
					addr_q <= addr_word;
					state_q <= SPI_DATA;
				end
				if (frame_end)
					state_q <= SPI_DONE;
			end
		end
	end

	// read data: loaded after the address, shifted out on falling edges
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			out_q <= 16'h0000;
			miso_q <= 1'b0;
		end
		else if (csn)
		begin
			out_q <= 16'h0000;
			miso_q <= 1'b0;
		end
		else if (sclk_rise && state_q == SPI_ADDR && bit_cnt_q == 5'(`ADDR_BITS - 1))
		begin
			if (!addr_word[`ADDR_BITS-1] && addr_word[`ADDR_BITS-2:0] == `CTRL_ADDR)
				out_q <= ctrl_q;
			else
				out_q <= 16'h0000;
		end
		else if (sclk_fall && state_q == SPI_DATA)
		begin
			miso_q <= out_q[`DATA_BITS-1];
			out_q <= {out_q[`DATA_BITS-2:0], 1'b0};
		end
	end

	// next control value; unused and reserved bits never stored
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (!serial_reset_n || soft_rst)
			ctrl_d = `CTRL_RESET;
		else if (wr_ctrl)
			ctrl_d = data_word & `CTRL_WMASK;
	end

	// control register
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			ctrl_q <= `CTRL_RESET;
		else
			ctrl_q <= ctrl_d;
	end

	// a realign is owed after layout change or test enable; set beats clear
	assign layout_change = (ctrl_d[5:0] != ctrl_q[5:0])
		|| (ctrl_d[`TEST_BIT] && !ctrl_q[`TEST_BIT]);
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			pending_q <= 1'b0;
		else
			pending_q <= layout_change || (pending_q && !realign_seen);
	end

	// registered decode of the stored fields
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			status_q <= mode_status_t'(`STATUS_RESET); // decode of the default fields
		else
			status_q <= decode(ctrl_q);
	end

	// outputs straight from their flip-flops
	assign miso = miso_q;
	assign mode_status = status_q;
	assign realign_pending = pending_q;

endmodule

// ---- inc/mode_ctrl_params.svh ----
// constants of the converter control register and its serial access
// assumes inclusion by every file that decodes or drives the register
`ifndef MODE_CTRL_PARAMS_SVH
`define MODE_CTRL_PARAMS_SVH

`define ADDR_BITS 8
`define DATA_BITS 16
`define FRAME_BITS 24
`define CTRL_ADDR 7'h01
`define SOFT_RESET_ADDR 7'h04
`define SOFT_RESET_BIT 0
`define CTRL_RESET 16'h0000
`define STATUS_RESET 10'h078
`define CTRL_WMASK 16'h11bf
`define GROUP_LSB 0
`define PD_LSB 4
`define GRAY_BIT 7
`define BW_BIT 8
`define TEST_BIT 12

`endif

// ---- inc/mode_ctrl_pkg.sv ----
// types shared by the converter control register logic
// assumes mode_ctrl_params.svh supplies the numeric constants
package mode_ctrl_pkg;

	// core grouping, gray coded
	typedef enum logic [1:0]
	{
		GROUP_QUAD = 2'b00,
		GROUP_DUAL = 2'b01,
		GROUP_SINGLE = 2'b11,
		GROUP_COMMON = 2'b10
	} grouping_t;

	// serial frame phases, gray coded
	typedef enum logic [1:0]
	{
		SPI_IDLE = 2'b00,
		SPI_ADDR = 2'b01,
		SPI_DATA = 2'b11,
		SPI_DONE = 2'b10
	} spi_state_t;

	// decoded operating setup driven to the analog cores
	typedef struct packed
	{
		grouping_t grouping;
		logic [1:0] route_sel;
		logic [3:0] core_active;
		logic gray_sel;
		logic input_bw_sel;
		logic test_pattern_en;
	} mode_status_t;

endpackage

// ---- verification/mc_chk_assertions.sv ----
// port checker for converter_control
// assumes a bind into converter_control, one clock domain on mclk
`timescale 1ns/1ps
module mc_chk
	import mode_ctrl_pkg::*;
(
	input logic mclk,
	input logic arst_n,
	input logic serial_reset_n,
	input logic sclk,
	input logic csn,
	input logic miso,
	input logic realign_pulse_p,
	input logic realign_pulse_n,
	input mode_status_t mode_status,
	input logic realign_pending
);
	mode_status_t m;
	logic clr;
	// short views of the watched ports
	assign m = mode_status;
	assign clr = realign_pulse_p && !realign_pulse_n;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_idle; csn && $past(csn) |-> !miso; endproperty
	a_idle: assert property (p_idle) else $error("miso busy");
	property p_qrt; m.grouping == GROUP_QUAD |-> m.route_sel == 2'h0; endproperty
	a_qrt: assert property (p_qrt) else $error("quad route");
	property p_qact; m.grouping == GROUP_QUAD |-> m.core_active inside {4'hf, 4'hc, 4'h3, 4'h0}; endproperty
	a_qact: assert property (p_qact) else $error("quad standby");
	property p_fact; m.grouping[1] |-> m.core_active inside {4'hf, 4'h0}; endproperty
	a_fact: assert property (p_fact) else $error("full standby");
	property p_hold; (csn && serial_reset_n) [*4] |=> $stable(m); endproperty
	a_hold: assert property (p_hold) else $error("mode moved");
	property p_rst; !serial_reset_n [*3] |=> m == 10'h078; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_mhold; !csn && sclk && $past(sclk) && $past(sclk, 2) |=> $stable(miso); endproperty
	a_mhold: assert property (p_mhold) else $error("miso moved");
	property p_clr; $fell(realign_pending) |-> $past(clr) || $past(clr, 2); endproperty
	a_clr: assert property (p_clr) else $error("pending lost");
	c_dual: cover property (m.grouping == GROUP_DUAL);
	c_pend: cover property ($rose(realign_pending));
	c_test: cover property (m.test_pattern_en);
endmodule
bind converter_control mc_chk mc_chk_inst (.*);

// ---- verification/spi_host.sv ----
// serial host model issuing frames msb first
// assumes mclk runs free and the bench calls xfer
`timescale 1ns/1ps
module spi_host
(
	input logic mclk,
	input logic miso,
	output logic sclk = 1'b0,
	output logic csn = 1'b1,
	output logic mosi = 1'b0
);
	logic [15:0] rd;
	// first n bits of a frame; csn rises before the last fall
	task automatic xfer(input logic [23:0] f, input int n);
		@(negedge mclk) csn = 1'b0;
		for (int i = 23; i >= 24 - n; i--)
		begin
			@(negedge mclk) mosi = f[i];
			repeat (3) @(negedge mclk);
			rd = {rd[14:0], miso};
			sclk = 1'b1;
			repeat (4) @(negedge mclk);
			if (i > 24 - n)
				sclk = 1'b0;
		end
		csn = 1'b1;
		mosi = ~mosi;
		repeat (2) @(negedge mclk);
		sclk = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for converter_control over its serial port
// assumes spi_host drives the serial pins and mc_chk is bound in
`timescale 1ns/1ps
`include "mode_ctrl_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top
	import mode_ctrl_pkg::*;
;
	logic mclk = 1'b0, arst_n = 1'b0, srst_n = 1'b1, rp = 1'b0, sclk, csn, mosi, miso, pend;
	mode_status_t ms, got, e;
	logic [15:0] d, prev = 16'h0;
	logic [3:0] mk;
	int errors = 0, samples_checked = 0, cyc = 0;
	grouping_t gt [4] = '{GROUP_QUAD, GROUP_DUAL, GROUP_SINGLE, GROUP_COMMON};
	converter_control converter_control_inst (.mclk(mclk), .arst_n(arst_n),
		.serial_reset_n(srst_n), .sclk(sclk), .csn(csn), .mosi(mosi), .miso(miso),
		.realign_pulse_p(rp), .realign_pulse_n(~rp), .mode_status(ms), .realign_pending(pend));
	spi_host spi_host_inst (.mclk(mclk), .miso(miso), .sclk(sclk), .csn(csn), .mosi(mosi));
	// 200 MHz clock
	always #2.5 mclk = ~mclk;
	// verdict and end of run
	task automatic complete_run;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// wait for the decode and compare it, cores outside a pair masked
	task automatic chk_ms(input logic [15:0] v);
		mk = (v[3:2] == 2'h1) ? {v[1], ~v[1], v[0], ~v[0]} : 4'hf;
		e = {gt[v[3:2]], (v[3:2] == 2'h0) ? 2'h0 : v[1:0], 4'h0, v[7], v[8], v[12]};
		e.core_active = v[3] ? {4{v[5:4] == 2'h0}} : mk & {{2{~v[5]}}, {2{~v[4]}}};
		repeat (4) @(negedge mclk);
		got = ms;
		got.core_active = ms.core_active & mk;
		`CHK(got, e)
	endtask
	// host realign pulse, then nothing is owed
	task automatic pulse;
		@(negedge mclk) rp = 1'b1;
		repeat (2) @(negedge mclk);
		rp = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK(pend, 1'b0)
	endtask
	// hang guard
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			errors++;
			complete_run;
		end
	end
	// every grouping and standby code, then aborts, resets and foreign addresses
	initial
	begin
		repeat (4) @(negedge mclk);
		arst_n = 1'b1;
		chk_ms(16'h0);
		for (int i = 0; i < 64; i++)
		begin
			d = 16'hc640 | i[5:0] | {i[0], 7'h0} | {i[1], 8'h0} | {i[0] ^ i[5], 12'h0};
			spi_host_inst.xfer({8'h81, d}, 24);
			chk_ms(d);
			`CHK(pend, (d[5:0] != prev[5:0]) || (d[12] && !prev[12]))
			pulse;
			spi_host_inst.xfer({8'h01, 16'h0}, 24);
			`CHK(spi_host_inst.rd, d & `CTRL_WMASK)
			prev = d;
		end
		spi_host_inst.xfer({8'h81, 16'h0023}, 12);
		spi_host_inst.xfer({8'h85, 16'h0023}, 24);
		chk_ms(d);
		spi_host_inst.xfer({8'h02, 16'h0}, 24);
		`CHK(spi_host_inst.rd, 16'h0)
		spi_host_inst.xfer({8'h84, 16'h0001}, 24);
		chk_ms(16'h0);
		pulse;
		spi_host_inst.xfer({8'h81, 16'h003e}, 24);
		@(negedge mclk) srst_n = 1'b0;
		repeat (3) @(negedge mclk);
		srst_n = 1'b1;
		chk_ms(16'h0);
		complete_run;
	end
endmodule
